// >>> bench/tb_top.sv
module tb_top
    import ted_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset = 1'b1, sample_valid = 1'b0;
    logic rd_req = 1'b0, rd_comb = 1'b0;
    ted_sample_type accel_sample = '0;
    ted_cfg_type cfg = '0;
    logic status_read, combined_read, first_irq_pin, second_irq_pin;
    logic [7:0] tap_event_status, host_seen;
    int failures = 0, n_compared = 0;

    ted_tap_event_detector i_dut (.mclk(mclk), .reset(reset),
        .sample_valid(sample_valid), .accel_sample(accel_sample), .cfg(cfg),
        .status_read(status_read), .combined_read(combined_read),
        .first_irq_pin(first_irq_pin), .second_irq_pin(second_irq_pin),
        .tap_event_status(tap_event_status));
    ted_host_model i_host (.mclk(mclk), .read_req(rd_req), .read_comb(rd_comb),
        .tap_event_status(tap_event_status), .status_read(status_read),
        .combined_read(combined_read), .host_seen(host_seen));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_st(string w, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk_st

    task automatic chk_pin(string w, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", w, e, g);
        end
    endtask : chk_pin

    function automatic logic [7:0] est(logic s, logic d, logic n, logic [1:0] a);
        logic [7:0] v;
        v = 8'h00;
        v[STAT_ANY_BIT] = s | d;
        v[STAT_SINGLE_BIT] = s;
        v[STAT_DOUBLE_BIT] = d;
        v[STAT_SIGN_BIT] = n;
        v[STAT_X_BIT - a] = 1'b1;
        return v;
    endfunction : est

    function automatic logic [1:0] top_axis(logic [2:0] code);
        case (code)
            3'h1, 3'h5: return AXIS_Y;
            3'h3, 3'h6, 3'h7: return AXIS_Z;
            default: return AXIS_X;
        endcase
    endfunction : top_axis

    // One sample every four cycles keeps the rate steady
    task automatic samp(int n);
        repeat (n) begin
            sample_valid = 1'b1;
            @(negedge mclk);
            sample_valid = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask : samp

    task automatic tap(int dx, int dy, int dz);
        accel_sample.x = accel_sample.x + 16'(dx);
        accel_sample.y = accel_sample.y + 16'(dy);
        accel_sample.z = accel_sample.z + 16'(dz);
        samp(2);
    endtask : tap

    task automatic ramp(int n, int d);
        repeat (n) begin
            accel_sample.z = accel_sample.z + 16'(d);
            samp(1);
        end
        samp(1);
    endtask : ramp

    task automatic rd(int k);
        rd_req = (k == 0);
        rd_comb = (k != 0);
        @(negedge mclk);
        rd_req = 1'b0;
        rd_comb = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : rd

    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        wrap_up();
    end

    initial begin
        int th;
        int d;
        void'($urandom(22));
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        cfg.global_function_irq_en = 1'b1;
        cfg.x_en = 1'b1;
        cfg.y_en = 1'b1;
        cfg.z_en = 1'b1;
        cfg.pin1_single_route = 1'b1;
        cfg.pin2_double_route = 1'b1;
        cfg.x_hit_threshold = 5'h01;
        cfg.y_hit_threshold = 5'h01;
        th = 1 + $urandom_range(6);
        cfg.z_hit_threshold = 5'(th);
        tap(0, 0, th * 2048);
        chk_st("at threshold", 8'h00, tap_event_status);
        tap(0, 0, -(th * 2048 + 2));
        chk_st("neg tap", est(1'b1, 1'b0, 1'b1, AXIS_Z), tap_event_status);
        chk_pin("pin1", 1'b1, first_irq_pin);
        chk_pin("pin2", 1'b0, second_irq_pin);
        samp(1);
        chk_pin("hush hold", 1'b1, first_irq_pin);
        samp(2);
        chk_pin("hush end", 1'b0, first_irq_pin);
        $display("test threshold done");
        cfg.z_hit_threshold = 5'h01;
        for (int i = 0; i < 4; i++) begin
            cfg.shock_window = 2'(i / 2);
            d = (i % 2) ? -2050 : 2050;
            ramp(4 * (i / 2 + 1) + ((i % 2) ? 1 : -1), d);
            // Sign and axis bits keep the last tap once the flags fall
            chk_st("shock", (i % 2) ? 8'h01 : est(1'b1, 1'b0, 1'b0, AXIS_Z),
                tap_event_status);
            samp(3);
        end
        $display("test shock done");
        for (int c = 0; c < 9; c++) begin
            cfg.priority_code = 3'(c);
            cfg.x_en = (c < 8);
            d = (c % 2) ? -2050 : 2050;
            tap(d, d, d);
            chk_st("priority", est(1'b1, 1'b0, 1'(c % 2),
                (c < 8) ? top_axis(3'(c)) : AXIS_Y), tap_event_status);
            samp(3);
        end
        cfg.x_en = 1'b1;
        cfg.global_function_irq_en = 1'b0;
        tap(0, 0, 2050);
        chk_st("global off", 8'h02, tap_event_status);
        cfg.global_function_irq_en = 1'b1;
        samp(2);
        $display("test priority done");
        cfg.single_double = 1'b1;
        cfg.latch_request = 1'b1;
        for (int k = 0; k < 2; k++) begin
            tap(0, 0, -2050);
            chk_st("first", est(1'b1, 1'b0, 1'b1, AXIS_Z), tap_event_status);
            samp(3);
            tap(0, 0, 2050);
            chk_st("double", est(1'b0, 1'b1, 1'b0, AXIS_Z),
                tap_event_status);
            samp(8);
            chk_pin("latched", 1'b1, second_irq_pin);
            if (k == 0) begin
                tap(0, 0, -2050);
                chk_st("held", 8'h01, tap_event_status & 8'h0f);
            end
            rd(k);
            chk_pin("read clears", 1'b0, second_irq_pin);
            if (k == 0) begin
                chk_st("read value", est(1'b1, 1'b1, 1'b0, AXIS_Z), host_seen);
            end
            samp(24);
        end
        for (int k = 0; k < 2; k++) begin
            tap(0, 0, -2050);
            samp(k ? 20 : 0);
            tap(0, 0, 2050);
            chk_st("no double", 8'h00, tap_event_status & 8'h10);
            samp(24);
        end
        $display("test double done");
        cfg.single_double = 1'b0;
        cfg.pin1_single_route = 1'b0;
        tap(0, 0, -2050);
        samp(3);
        chk_st("unrouted latch", 8'h09, tap_event_status);
        tap(0, 0, 2050);
        chk_st("single only", 8'h00, tap_event_status & 8'h10);
        $display("test single mode done");
        wrap_up();
    end
endmodule : tb_top

// >>> bench/ted_host_model.sv
module ted_host_model
    import ted_pkg::*;
(
    input wire logic mclk,
    input wire logic read_req,
    input wire logic read_comb,
    input wire logic [7:0] tap_event_status,
    output logic status_read = 1'b0,
    output logic combined_read = 1'b0,
    output logic [7:0] host_seen = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle read strobes, launched just after the rising edge
    always @(posedge mclk) begin
        status_read <= read_req;
        combined_read <= read_comb;
        if (status_read) begin
            host_seen <= tap_event_status;
        end
    end
endmodule : ted_host_model

// >>> bench/ted_tap_checker.sv
module ted_tap_checker
    import ted_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire ted_sample_type accel_sample,
    input wire ted_cfg_type cfg,
    input wire logic status_read,
    input wire logic combined_read,
    input wire logic first_irq_pin,
    input wire logic second_irq_pin,
    input wire logic [7:0] tap_event_status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic [7:0] st = tap_event_status;
    wire logic new_evt = st[STAT_ANY_BIT];

    sequence s_dbl_latched;
        cfg.latch_request && cfg.single_double && st[STAT_DOUBLE_BIT]
            && (cfg.pin1_double_route || cfg.pin2_double_route);
    endsequence
    sequence s_no_read;
        !status_read && !combined_read;
    endsequence
    sequence s_quiet_read;
        (status_read || combined_read) && !sample_valid && !$past(sample_valid);
    endsequence

    AST_TOP_BIT: assert property (st[7] == 1'b0)
        else $error("status bit 7 set");
    AST_ANY_IS_OR: assert property (
        new_evt == (st[STAT_SINGLE_BIT] || st[STAT_DOUBLE_BIT]))
        else $error("any flag differs from single or double");
    AST_GLOBAL_OFF: assert property (
        !cfg.global_function_irq_en |-> !$rose(new_evt))
        else $error("tap raised while functions disabled");
    AST_NO_DOUBLE: assert property (
        !cfg.single_double |-> !$rose(st[STAT_DOUBLE_BIT]))
        else $error("double tap in single mode");
    AST_AFTER_SAMPLE: assert property (
        $rose(new_evt) |-> $past(sample_valid) || $past(sample_valid, 2))
        else $error("tap event without a new sample");
    AST_ONE_AXIS: assert property (
        $rose(new_evt) |-> $onehot(st[2:0]))
        else $error("tap event not on exactly one axis");
    AST_AXIS_EN: assert property (
        $rose(new_evt) |-> (cfg.x_en || !st[STAT_X_BIT])
            && (cfg.y_en || !st[STAT_Y_BIT]) && (cfg.z_en || !st[STAT_Z_BIT]))
        else $error("tap reported on a disabled axis");
    AST_PIN1_SRC: assert property (
        $rose(first_irq_pin) |-> (st[STAT_SINGLE_BIT] && cfg.pin1_single_route)
            || (st[STAT_DOUBLE_BIT] && cfg.pin1_double_route))
        else $error("first pin raised without a routed tap");
    AST_PIN2_SRC: assert property (
        $rose(second_irq_pin) |-> (st[STAT_SINGLE_BIT] && cfg.pin2_single_route)
            || (st[STAT_DOUBLE_BIT] && cfg.pin2_double_route))
        else $error("second pin raised without a routed tap");
    AST_LATCH_HOLD: assert property (
        s_dbl_latched ##0 s_no_read |=> st[STAT_DOUBLE_BIT])
        else $error("latched double tap dropped without a read");
    AST_READ_CLEAR: assert property (
        s_dbl_latched ##0 s_quiet_read |=> !st[STAT_DOUBLE_BIT])
        else $error("latched double tap kept after a read");
endmodule : ted_tap_checker

bind ted_tap_event_detector ted_tap_checker i_chk (.mclk(mclk), .reset(reset),
    .sample_valid(sample_valid), .accel_sample(accel_sample), .cfg(cfg),
    .status_read(status_read), .combined_read(combined_read),
    .first_irq_pin(first_irq_pin), .second_irq_pin(second_irq_pin),
    .tap_event_status(tap_event_status));

// >>> core/ted_pkg.sv
package ted_pkg;
    // Status register bit positions
    localparam int STAT_ANY_BIT = 6;
    localparam int STAT_SINGLE_BIT = 5;
    localparam int STAT_DOUBLE_BIT = 4;
    localparam int STAT_SIGN_BIT = 3;
    localparam int STAT_X_BIT = 2;
    localparam int STAT_Y_BIT = 1;
    localparam int STAT_Z_BIT = 0;
    localparam logic [7:0] TAP_EVENT_STATUS_ADDR = 8'h46;
    localparam logic [7:0] TAP_EVENT_STATUS_RST = 8'h00;

    // Window lengths in sample periods: zero code, then per count
    localparam logic [8:0] SHOCK_ZERO_LEN = 9'h004;
    localparam logic [8:0] SHOCK_STEP_LEN = 9'h008;
    localparam logic [8:0] QUIET_ZERO_LEN = 9'h002;
    localparam logic [8:0] QUIET_STEP_LEN = 9'h004;
    localparam logic [8:0] GAP_ZERO_LEN = 9'h010;
    localparam logic [8:0] GAP_STEP_LEN = 9'h020;

    // One threshold count is full scale / 32 of a 16-bit sample
    localparam int THS_SHIFT = 10;

    localparam logic [1:0] AXIS_X = 2'h0;
    localparam logic [1:0] AXIS_Y = 2'h1;
    localparam logic [1:0] AXIS_Z = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SHOCK1 = 3'b001,
        ST_QUIET = 3'b010,
        ST_GAP = 3'b011,
        ST_SHOCK2 = 3'b100,
        ST_SETTLE = 3'b101
    } ted_state_type;

    typedef struct packed {
        logic x_en;
        logic y_en;
        logic z_en;
        logic latch_request;
        logic global_function_irq_en;
        logic [4:0] x_hit_threshold;
        logic [2:0] priority_code;
        logic [4:0] y_hit_threshold;
        logic [4:0] z_hit_threshold;
        logic [1:0] shock_window;
        logic [1:0] hush_window;
        logic [3:0] gap_window;
        logic single_double;
        logic pin1_single_route;
        logic pin2_single_route;
        logic pin1_double_route;
        logic pin2_double_route;
    } ted_cfg_type;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } ted_sample_type;
endpackage : ted_pkg

// >>> core/ted_tap_event_detector.sv
// Behaviour
// - Slope is half of sample difference
// - Detection runs only with global enable
// - Tap needs fall below within impact window
// - Pulse lasts hush window, latch until read
// - Select bit chooses single only or both
// - Second tap starts after hush, before gap
// - Second tap uses same impact criterion
// - Over-threshold during hush cancels double tap
// - Gap window starts when hush ends
// - Each axis has own enable bit
// - Only highest priority exceeding axis evaluated
// - Three-bit priority code decode table
// - Impact window 4 or 8 per count
// - Hush window 2 or 4 per count
// - Gap window 16 or 32 per count
// - Single and double routable per pin
// - Status shows any, single, double, sign, axes
// - Latch targets single or double by select
// - Latched sign and axes held until read
// - Latch ignored when tap not routed
module ted_tap_event_detector
    import ted_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire ted_sample_type accel_sample,
    input wire ted_cfg_type cfg,
    input wire logic status_read,
    input wire logic combined_read,
    output logic first_irq_pin,
    output logic second_irq_pin,
    output logic [7:0] tap_event_status
);

    typedef struct packed {
        ted_state_type fsm;
        ted_sample_type prev;
        logic [8:0] win_cnt;
        logic [8:0] hold_cnt;
        logic [1:0] axis;
        logic cur_sign;
        logic spoiled;
        logic after_double;
        logic single_on;
        logic double_on;
        logic single_latched;
        logic double_latched;
        logic sign_f;
        logic [2:0] axis_f;
        logic pin1;
        logic pin2;
        logic [7:0] status;
    } ted_regs_type;

    ted_regs_type regs_r;
    ted_regs_type regs_nxt;

    function automatic logic [8:0] win_len(input logic [3:0] code,
                                           input logic [8:0] zero_len,
                                           input logic [8:0] step_len);
        logic [8:0] len;
        len = (code == 4'h0) ? zero_len : 9'(code * step_len);
        return len;
    endfunction : win_len

    function automatic logic signed [15:0] slope_of(
        input logic signed [15:0] cur,
        input logic signed [15:0] prev);
        logic signed [16:0] diff;
        diff = {cur[15], cur} - {prev[15], prev};
        return diff[16:1];
    endfunction : slope_of

    function automatic logic over_ths(input logic signed [15:0] slope,
                                      input logic [4:0] ths);
        logic [15:0] mag;
        mag = slope[15] ? 16'(-slope) : 16'(slope);
        return mag > 16'({ths, {THS_SHIFT{1'b0}}});
    endfunction : over_ths

    // Highest priority axis among those exceeding
    function automatic logic [1:0] pick_axis(input logic [2:0] over,
                                             input logic [2:0] code);
        logic [5:0] order;
        logic [1:0] sel;
        case (code)
            3'b000: order = {AXIS_X, AXIS_Y, AXIS_Z};
            3'b001: order = {AXIS_Y, AXIS_X, AXIS_Z};
            3'b010: order = {AXIS_X, AXIS_Z, AXIS_Y};
            3'b011: order = {AXIS_Z, AXIS_Y, AXIS_X};
            3'b100: order = {AXIS_X, AXIS_Y, AXIS_Z};
            3'b101: order = {AXIS_Y, AXIS_Z, AXIS_X};
            3'b110: order = {AXIS_Z, AXIS_X, AXIS_Y};
            default: order = {AXIS_Z, AXIS_Y, AXIS_X};
        endcase
        if (over[order[5:4]]) begin
            sel = order[5:4];
        end else if (over[order[3:2]]) begin
            sel = order[3:2];
        end else begin
            sel = order[1:0];
        end
        return sel;
    endfunction : pick_axis

    logic signed [15:0] slope_x;
    logic signed [15:0] slope_y;
    logic signed [15:0] slope_z;
    logic [2:0] over;
    logic [2:0] signs;
    logic [8:0] shock_len;
    logic [8:0] quiet_len;
    logic [8:0] gap_len;
    logic lat_single;
    logic lat_double;

    always_comb begin
        slope_x = slope_of(accel_sample.x, regs_r.prev.x);
        slope_y = slope_of(accel_sample.y, regs_r.prev.y);
        slope_z = slope_of(accel_sample.z, regs_r.prev.z);
        over[AXIS_X] = cfg.x_en & over_ths(slope_x, cfg.x_hit_threshold);
        over[AXIS_Y] = cfg.y_en & over_ths(slope_y, cfg.y_hit_threshold);
        over[AXIS_Z] = cfg.z_en & over_ths(slope_z, cfg.z_hit_threshold);
        signs = {slope_z[15], slope_y[15], slope_x[15]};
        shock_len = win_len({2'h0, cfg.shock_window},
                            SHOCK_ZERO_LEN, SHOCK_STEP_LEN);
        quiet_len = win_len({2'h0, cfg.hush_window},
                            QUIET_ZERO_LEN, QUIET_STEP_LEN);
        gap_len = win_len(cfg.gap_window, GAP_ZERO_LEN, GAP_STEP_LEN);
        lat_single = cfg.latch_request & ~cfg.single_double
                     & (cfg.pin1_single_route | cfg.pin2_single_route);
        lat_double = cfg.latch_request & cfg.single_double
                     & (cfg.pin1_double_route | cfg.pin2_double_route);
    end

    logic ev_single;
    logic ev_double;
    logic clear_read;

    always_comb begin
        regs_nxt = regs_r;
        ev_single = 1'b0;
        ev_double = 1'b0;
        clear_read = status_read | combined_read;

        if (sample_valid) begin
            regs_nxt.prev = accel_sample;
            regs_nxt.win_cnt = regs_r.win_cnt + 9'h001;
            if (regs_r.hold_cnt != 9'h000) begin
                regs_nxt.hold_cnt = regs_r.hold_cnt - 9'h001;
            end
        end

        if (!cfg.global_function_irq_en) begin
            regs_nxt.fsm = ST_IDLE;
            regs_nxt.win_cnt = 9'h000;
        end else if (sample_valid) begin
            case (regs_r.fsm)
                ST_IDLE: begin
                    if (over != 3'b000) begin
                        regs_nxt.axis = pick_axis(over, cfg.priority_code);
                        regs_nxt.cur_sign = signs[regs_nxt.axis];
                        regs_nxt.win_cnt = 9'h001;
                        regs_nxt.fsm = ST_SHOCK1;
                    end
                end
                ST_SHOCK1, ST_SHOCK2: begin
                    if (!over[regs_r.axis]) begin
                        regs_nxt.win_cnt = 9'h000;
                        regs_nxt.spoiled = 1'b0;
                        regs_nxt.fsm = ST_QUIET;
                        if (regs_r.fsm == ST_SHOCK1) begin
                            ev_single = 1'b1;
                            regs_nxt.after_double = 1'b0;
                        end else begin
                            ev_double = 1'b1;
                            regs_nxt.after_double = 1'b1;
                        end
                    end else if (regs_r.win_cnt >= shock_len) begin
                        regs_nxt.fsm = ST_SETTLE;
                    end
                end
                ST_QUIET: begin
                    if (over[regs_r.axis]) begin
                        regs_nxt.spoiled = 1'b1;
                    end
                    if (regs_nxt.win_cnt >= quiet_len) begin
                        regs_nxt.win_cnt = 9'h000;
                        if (cfg.single_double && !regs_r.after_double
                            && !regs_nxt.spoiled) begin
                            regs_nxt.fsm = ST_GAP;
                        end else begin
                            regs_nxt.fsm = over[regs_r.axis] ? ST_SETTLE
                                                             : ST_IDLE;
                        end
                    end
                end
                ST_GAP: begin
                    if (over[regs_r.axis]) begin
                        regs_nxt.cur_sign = signs[regs_r.axis];
                        regs_nxt.win_cnt = 9'h001;
                        regs_nxt.fsm = ST_SHOCK2;
                    end else if (regs_nxt.win_cnt >= gap_len) begin
                        regs_nxt.fsm = ST_IDLE;
                    end
                end
                ST_SETTLE: begin
                    if (over == 3'b000) begin
                        regs_nxt.fsm = ST_IDLE;
                    end
                end
                default: begin
                    regs_nxt.fsm = ST_IDLE;
                end
            endcase
        end

        // Pulsed flags fall when the hush count runs out
        if (regs_r.hold_cnt != 9'h000 && regs_nxt.hold_cnt == 9'h000) begin
            if (!regs_r.single_latched) begin
                regs_nxt.single_on = 1'b0;
            end
            if (!regs_r.double_latched) begin
                regs_nxt.double_on = 1'b0;
            end
        end
        if (clear_read) begin
            // A running hush count may belong to a newer tap, so the
            // read drops the latched flag outright
            if (regs_r.single_latched) begin
                regs_nxt.single_latched = 1'b0;
                regs_nxt.single_on = 1'b0;
            end
            if (regs_r.double_latched) begin
                regs_nxt.double_latched = 1'b0;
                regs_nxt.double_on = 1'b0;
            end
        end

        // A new event wins over a clear in the same cycle
        if (ev_single || ev_double) begin
            regs_nxt.hold_cnt = quiet_len;
            if (!(regs_r.single_latched || regs_r.double_latched)
                || clear_read) begin
                regs_nxt.sign_f = regs_r.cur_sign;
                regs_nxt.axis_f = 3'b001 << regs_r.axis;
            end
        end
        if (ev_single) begin
            regs_nxt.single_on = 1'b1;
            regs_nxt.single_latched = lat_single;
        end
        if (ev_double) begin
            regs_nxt.double_on = 1'b1;
            regs_nxt.double_latched = lat_double;
        end

        regs_nxt.pin1 = (regs_nxt.single_on & cfg.pin1_single_route)
                      | (regs_nxt.double_on & cfg.pin1_double_route);
        regs_nxt.pin2 = (regs_nxt.single_on & cfg.pin2_single_route)
                      | (regs_nxt.double_on & cfg.pin2_double_route);

        regs_nxt.status = TAP_EVENT_STATUS_RST;
        regs_nxt.status[STAT_ANY_BIT] = regs_nxt.single_on
                                      | regs_nxt.double_on;
        regs_nxt.status[STAT_SINGLE_BIT] = regs_nxt.single_on;
        regs_nxt.status[STAT_DOUBLE_BIT] = regs_nxt.double_on;
        regs_nxt.status[STAT_SIGN_BIT] = regs_nxt.sign_f;
        regs_nxt.status[STAT_X_BIT] = regs_nxt.axis_f[AXIS_X];
        regs_nxt.status[STAT_Y_BIT] = regs_nxt.axis_f[AXIS_Y];
        regs_nxt.status[STAT_Z_BIT] = regs_nxt.axis_f[AXIS_Z];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            regs_r <= '0;
            regs_r.fsm <= ST_IDLE;
            regs_r.status <= TAP_EVENT_STATUS_RST;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign first_irq_pin = regs_r.pin1;
    assign second_irq_pin = regs_r.pin2;
    assign tap_event_status = regs_r.status;

endmodule : ted_tap_event_detector
